// *** design/hsf_pkg.sv ***
// Shared constants, states and carriers for the sequence, stream and page register block
package hsf_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h02;
  localparam logic [7:0] OFS_SLOT_FIRST = 8'h03;
  localparam logic [7:0] OFS_SLOT_LAST = 8'h0A;
  localparam logic [7:0] OFS_STREAM = 8'h0B;
  localparam logic [7:0] OFS_PAGE = 8'hFF;

  // ----------------------------------------------------------------
  // Fields, reset values and counts
  // ----------------------------------------------------------------
  localparam int GO_BIT = 0;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] PAGE_CONTROL = 8'h00;
  localparam logic [7:0] ID_END = 8'h00;
  localparam int SLOT_COUNT = 8;
  localparam logic [2:0] SLOT_IDX_FIRST = 3'h0;
  localparam logic [2:0] SLOT_IDX_LAST = 3'h7;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam int BYTE_W = 8;
  localparam int STREAM_DEPTH = 16;
  // Arbitrary value, set per board
  localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h2A;

  // ----------------------------------------------------------------
  // State encodings
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    I2C_IDLE = 3'b000,
    I2C_DEV = 3'b001,
    I2C_REG = 3'b010,
    I2C_WR = 3'b011,
    I2C_RD = 3'b100
  } hsf_i2c_state_type;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_FETCH = 2'b01,
    SEQ_WAIT = 2'b10
  } hsf_seq_state_type;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic start;
    logic [7:0] id;
  } hsf_play_type;

  typedef struct packed {
    logic wr;
    logic [7:0] page;
    logic [7:0] addr;
    logic [7:0] wdata;
  } hsf_mem_req_type;

endpackage : hsf_pkg

// *** design/hsf_stream_fifo.sv ***
// Byte FIFO between the stream entry register and the playback datapath
`timescale 1ns/10ps
module hsf_stream_fifo
  import hsf_pkg::*;
#(
  parameter int WIDTH = BYTE_W,
  parameter int DEPTH = STREAM_DEPTH
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] mem_d [DEPTH];
  logic [AW-1:0] wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d;
  logic [CW-1:0] count_q, count_d;
  logic push, pop;

  assign in_ready = (count_q != CW'(DEPTH));
  assign out_valid = (count_q != '0);
  assign out_data = mem_q[rd_ptr_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // ----------------------------------------------------------------
  // Pointers and storage
  // ----------------------------------------------------------------
  always_comb begin
    mem_d = mem_q;
    wr_ptr_d = wr_ptr_q;
    rd_ptr_d = rd_ptr_q;
    count_d = count_q;
    if (push) begin
      mem_d[wr_ptr_q] = in_data;
      wr_ptr_d = (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
    end
    if (pop) begin
      rd_ptr_d = (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
    end
    if (push && !pop) begin
      count_d = count_q + 1'b1;
    end else if (pop && !push) begin
      count_d = count_q - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= '0;
      end
    end else begin
      wr_ptr_q <= wr_ptr_d;
      rd_ptr_q <= rd_ptr_d;
      count_q <= count_d;
      mem_q <= mem_d;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_fifo_fill_track: assert property (@(posedge clk) disable iff (reset)
    push && !pop |=> count_q == $past(count_q) + 1'b1)
    else $error("fifo count did not rise on push");
  c_fifo_full: cover property (@(posedge clk) disable iff (reset) !in_ready);

endmodule : hsf_stream_fifo

// *** design/hsf_slot_walker.sv ***
// Walks the eight waveform sequence slots and launches each identifier up to the first zero
`timescale 1ns/10ps
module hsf_slot_walker
  import hsf_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic start,
  output logic [2:0] slot_idx,
  input wire logic [7:0] slot_id,
  input wire logic wave_done,
  output hsf_play_type play,
  output logic busy,
  output logic done
);
  hsf_seq_state_type st_q, st_d;
  logic [2:0] idx_q, idx_d;
  hsf_play_type play_q, play_d;
  logic done_q, done_d;

  assign slot_idx = idx_q;
  assign play = play_q;
  assign busy = (st_q != SEQ_IDLE);
  assign done = done_q;

  // ----------------------------------------------------------------
  // Walk state machine
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    idx_d = idx_q;
    play_d = '0;
    done_d = 1'b0;
    case (st_q)
      SEQ_IDLE: begin
        if (start) begin
          idx_d = SLOT_IDX_FIRST;
          st_d = SEQ_FETCH;
        end
      end
      SEQ_FETCH: begin
        if (slot_id == ID_END) begin
          st_d = SEQ_IDLE;
          done_d = 1'b1;
        end else begin
          play_d.start = 1'b1;
          play_d.id = slot_id;
          st_d = SEQ_WAIT;
        end
      end
      SEQ_WAIT: begin
        if (wave_done) begin
          if (idx_q == SLOT_IDX_LAST) begin
            st_d = SEQ_IDLE;
            done_d = 1'b1;
          end else begin
            idx_d = idx_q + 1'b1;
            st_d = SEQ_FETCH;
          end
        end
      end
      default: begin
        st_d = SEQ_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_q <= SEQ_IDLE;
      idx_q <= SLOT_IDX_FIRST;
      play_q <= '0;
      done_q <= 1'b0;
    end else begin
      st_q <= st_d;
      idx_q <= idx_d;
      play_q <= play_d;
      done_q <= done_d;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_walk_first_slot: assert property (
    st_q == SEQ_IDLE && start |=> st_q == SEQ_FETCH && idx_q == SLOT_IDX_FIRST)
    else $error("walk did not start at first slot");
  a_walk_plays_id: assert property (
    st_q == SEQ_FETCH && slot_id != ID_END |=> play_q.start && play_q.id == $past(slot_id))
    else $error("identifier not launched");
  a_walk_next_slot: assert property (
    st_q == SEQ_WAIT && wave_done && idx_q != SLOT_IDX_LAST
    |=> st_q == SEQ_FETCH && idx_q == $past(idx_q) + 3'h1)
    else $error("walk did not advance one slot");
  a_walk_zero_ends: assert property (
    st_q == SEQ_FETCH && slot_id == ID_END |=> st_q == SEQ_IDLE && done_q && !play_q.start)
    else $error("zero identifier did not end walk");
  a_walk_last_ends: assert property (
    st_q == SEQ_WAIT && wave_done && idx_q == SLOT_IDX_LAST |=> st_q == SEQ_IDLE && done_q)
    else $error("walk ran past last slot");
  c_walk_zero_stop: cover property (st_q == SEQ_FETCH && slot_id == ID_END && idx_q != 3'h0);
  c_walk_full: cover property (st_q == SEQ_WAIT && wave_done && idx_q == SLOT_IDX_LAST);

endmodule : hsf_slot_walker

// *** design/hsf_regs.sv ***
// Two-wire register slave with sequence slots, stream entry and page select
// ----------------------------------------------------------------
// Overview of operation
// - Go bit starts playback at slot offset 0x03, playing its identifier.
// - After each waveform finishes, move to the next slot from 0x04 onward.
// - A slot holding identifier zero ends playback; later slots are ignored.
// - Without a zero, playback ends after all 8 slots, last at 0x0A.
// - Each write to offset 0x0B under page zero pushes one byte into the waveform FIFO; a full FIFO refuses the byte with a NACK.
// - Register 0xFF holds the memory page number; resets to zero.
// - Page zero selects control space; host returns to zero before control use.
// ----------------------------------------------------------------
`timescale 1ns/10ps
module hsf_regs
  import hsf_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEFAULT
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic wave_done,
  output hsf_play_type play,
  output logic seq_busy,
  output logic [7:0] stream_data,
  output logic stream_valid,
  input wire logic stream_ready,
  output hsf_mem_req_type mem_req,
  input wire logic [7:0] mem_rdata
);
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  hsf_i2c_state_type st_q, st_d;
  logic scl_q, sda_q;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] sh_q, sh_d, ptr_q, ptr_d;
  logic ack_q, ack_d, mack_q, mack_d, drv_q, drv_d;
  logic wr_q, wr_d;
  logic [7:0] wr_addr_q, wr_addr_d, wr_data_q, wr_data_d;
  logic scl_rise, scl_fall, bus_start, bus_stop, to_stream;
  logic [7:0] ctrl_q, ctrl_d, page_q, page_d;
  logic [7:0] slot_q [SLOT_COUNT];
  logic [7:0] slot_d [SLOT_COUNT];
  hsf_mem_req_type mem_req_q, mem_req_d;
  logic seq_start, seq_done, fifo_in_ready;
  logic [2:0] slot_idx;

  // Byte visible at a register offset under the current page
  function automatic logic [7:0] reg_read(input logic [7:0] a);
    logic [7:0] v;
    v = RST_BYTE;
    if (a == OFS_PAGE) begin
      v = page_q;
    end else if (page_q != PAGE_CONTROL) begin
      v = mem_rdata;
    end else if (a == OFS_CTRL) begin
      v = ctrl_q;
    end else if (a >= OFS_SLOT_FIRST && a <= OFS_SLOT_LAST) begin
      v = slot_q[3'(a - OFS_SLOT_FIRST)];
    end
    return v;
  endfunction : reg_read

  // ----------------------------------------------------------------
  // Bus conditions
  // ----------------------------------------------------------------
  assign scl_rise = scl && !scl_q;
  assign scl_fall = !scl && scl_q;
  assign bus_start = scl && scl_q && sda_q && !sda_in;
  assign bus_stop = scl && scl_q && !sda_q && sda_in;
  assign to_stream = (ptr_q == OFS_STREAM) && (page_q == PAGE_CONTROL);
  assign sda_out = 1'b0;
  assign sda_oe_n = !drv_q;

  // ----------------------------------------------------------------
  // Two-wire slave
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    ptr_d = ptr_q;
    ack_d = ack_q;
    mack_d = mack_q;
    drv_d = drv_q;
    wr_d = 1'b0;
    wr_addr_d = wr_addr_q;
    wr_data_d = wr_data_q;
    if (bus_stop) begin
      st_d = I2C_IDLE;
      ack_d = 1'b0;
      mack_d = 1'b0;
      drv_d = 1'b0;
    end else if (bus_start) begin
      st_d = I2C_DEV;
      cnt_d = 4'h0;
      ack_d = 1'b0;
      mack_d = 1'b0;
      drv_d = 1'b0;
    end else if (scl_rise && st_q != I2C_IDLE) begin
      if (!ack_q) begin
        cnt_d = cnt_q + 4'h1;
        if (st_q != I2C_RD) begin
          sh_d = {sh_q[6:0], sda_in};
        end
      end else if (mack_q) begin
        if (sda_in) begin
          st_d = I2C_IDLE;
        end else begin
          ptr_d = ptr_q + 8'h01;
          sh_d = reg_read(ptr_q + 8'h01);
        end
      end
    end else if (scl_fall && st_q != I2C_IDLE) begin
      if (ack_q) begin
        ack_d = 1'b0;
        mack_d = 1'b0;
        cnt_d = 4'h0;
        drv_d = (st_q == I2C_RD) ? !sh_q[7] : 1'b0;
      end else if (cnt_q == BITS_PER_BYTE) begin
        ack_d = 1'b1;
        case (st_q)
          I2C_DEV: begin
            if (sh_q[7:1] == DEV_ADDR) begin
              drv_d = 1'b1;
              if (sh_q[0]) begin
                st_d = I2C_RD;
                sh_d = reg_read(ptr_q);
              end else begin
                st_d = I2C_REG;
              end
            end else begin
              st_d = I2C_IDLE;
              ack_d = 1'b0;
            end
          end
          I2C_REG: begin
            ptr_d = sh_q;
            drv_d = 1'b1;
            st_d = I2C_WR;
          end
          I2C_WR: begin
            if (to_stream && !fifo_in_ready) begin
              drv_d = 1'b0;
            end else begin
              drv_d = 1'b1;
              wr_d = 1'b1;
              wr_addr_d = ptr_q;
              wr_data_d = sh_q;
              if (!to_stream) begin
                ptr_d = ptr_q + 8'h01;
              end
            end
          end
          I2C_RD: begin
            drv_d = 1'b0;
            mack_d = 1'b1;
          end
          default: begin
            st_d = I2C_IDLE;
          end
        endcase
      end else if (st_q == I2C_RD) begin
        sh_d = {sh_q[6:0], 1'b0};
        drv_d = !sh_q[6];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_q <= I2C_IDLE;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      cnt_q <= 4'h0;
      sh_q <= RST_BYTE;
      ptr_q <= RST_BYTE;
      ack_q <= 1'b0;
      mack_q <= 1'b0;
      drv_q <= 1'b0;
      wr_q <= 1'b0;
      wr_addr_q <= RST_BYTE;
      wr_data_q <= RST_BYTE;
    end else begin
      st_q <= st_d;
      scl_q <= scl;
      sda_q <= sda_in;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      ptr_q <= ptr_d;
      ack_q <= ack_d;
      mack_q <= mack_d;
      drv_q <= drv_d;
      wr_q <= wr_d;
      wr_addr_q <= wr_addr_d;
      wr_data_q <= wr_data_d;
    end
  end

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  assign seq_start = wr_q && wr_addr_q == OFS_CTRL && page_q == PAGE_CONTROL
                     && wr_data_q[GO_BIT];

  always_comb begin
    ctrl_d = ctrl_q;
    page_d = page_q;
    slot_d = slot_q;
    mem_req_d = '0;
    if (seq_done) begin
      ctrl_d[GO_BIT] = 1'b0;
    end
    if (wr_q) begin
      if (wr_addr_q == OFS_PAGE) begin
        page_d = wr_data_q;
      end else if (page_q != PAGE_CONTROL) begin
        mem_req_d = '{wr: 1'b1, page: page_q, addr: wr_addr_q, wdata: wr_data_q};
      end else if (wr_addr_q == OFS_CTRL) begin
        ctrl_d = wr_data_q;
      end else begin
        for (int i = 0; i < SLOT_COUNT; i++) begin
          if (wr_addr_q == OFS_SLOT_FIRST + 8'(i)) begin
            slot_d[i] = wr_data_q;
          end
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl_q <= RST_BYTE;
      page_q <= RST_BYTE;
      mem_req_q <= '0;
      for (int i = 0; i < SLOT_COUNT; i++) begin
        slot_q[i] <= RST_BYTE;
      end
    end else begin
      ctrl_q <= ctrl_d;
      page_q <= page_d;
      mem_req_q <= mem_req_d;
      slot_q <= slot_d;
    end
  end

  assign mem_req = mem_req_q;

  // ----------------------------------------------------------------
  // Sequence walker and stream FIFO
  // ----------------------------------------------------------------
  hsf_slot_walker u_walker (
    .clk(clk),
    .reset(reset),
    .start(seq_start),
    .slot_idx(slot_idx),
    .slot_id(slot_q[slot_idx]),
    .wave_done(wave_done),
    .play(play),
    .busy(seq_busy),
    .done(seq_done)
  );

  hsf_stream_fifo #(
    .WIDTH(BYTE_W),
    .DEPTH(STREAM_DEPTH)
  ) u_fifo (
    .clk(clk),
    .reset(reset),
    .in_valid(wr_q && wr_addr_q == OFS_STREAM && page_q == PAGE_CONTROL),
    .in_ready(fifo_in_ready),
    .in_data(wr_data_q),
    .out_valid(stream_valid),
    .out_ready(stream_ready),
    .out_data(stream_data)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_stream_push: assert property (
    wr_q && wr_addr_q == OFS_STREAM && page_q == PAGE_CONTROL && !seq_done |=> stream_valid
    && ctrl_q == $past(ctrl_q))
    else $error("stream write did not enter fifo");
  a_page_store: assert property (
    wr_q && wr_addr_q == OFS_PAGE |=> page_q == $past(wr_data_q) && !mem_req_q.wr)
    else $error("page register not updated");
  a_page_divert: assert property (
    wr_q && wr_addr_q != OFS_PAGE && page_q != PAGE_CONTROL && !seq_done
    |=> mem_req_q.wr && ctrl_q == $past(ctrl_q) && mem_req_q.addr == $past(wr_addr_q))
    else $error("paged write reached control space");
  a_go_starts_walk: assert property (
    seq_start && !seq_busy |=> seq_busy ##1 (play.start || !seq_busy))
    else $error("go bit did not start playback");
  c_page_switch: cover property (wr_q && wr_addr_q == OFS_PAGE && wr_data_q != PAGE_CONTROL);
  c_stream_refused: cover property (st_q == I2C_WR && to_stream && !fifo_in_ready);

endmodule : hsf_regs

// *** test/hsf_host_model.sv ***
// Two-wire host controller model that reaches the register block
`timescale 1ns/10ps
module hsf_host_model
  import hsf_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEFAULT
) (
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sda_pull
);
  // ----------------------------------------------------------------
  // Bus idle and bit timing, four clocks per half bit
  // ----------------------------------------------------------------
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  task automatic half_bit();
    repeat (4) @(negedge clk);
  endtask : half_bit

  task automatic clock_bit(input logic b, output logic seen);
    @(negedge clk);
    sda_pull = ~b;
    half_bit();
    scl = 1'b1;
    half_bit();
    seen = sda;
    scl = 1'b0;
  endtask : clock_bit

  task automatic go_start();
    @(negedge clk);
    sda_pull = 1'b0;
    half_bit();
    scl = 1'b1;
    half_bit();
    sda_pull = 1'b1;
    half_bit();
    scl = 1'b0;
  endtask : go_start

  task automatic go_stop();
    @(negedge clk);
    sda_pull = 1'b1;
    half_bit();
    scl = 1'b1;
    half_bit();
    sda_pull = 1'b0;
    half_bit();
  endtask : go_stop

  task automatic put_byte(input logic [7:0] d, output logic nack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clock_bit(d[i], s);
    end
    clock_bit(1'b1, nack);
  endtask : put_byte

  task automatic get_byte(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clock_bit(1'b1, d[i]);
    end
    clock_bit(last, s);
  endtask : get_byte

  task automatic begin_write(input logic [7:0] ofs, output logic nack);
    logic n0;
    logic n1;
    go_start();
    put_byte({DEV_ADDR, 1'b0}, n0);
    put_byte(ofs, n1);
    nack = n0 | n1;
  endtask : begin_write

  task automatic write_reg(input logic [7:0] ofs, input logic [7:0] d, output logic nack);
    logic n0;
    logic n1;
    begin_write(ofs, n0);
    put_byte(d, n1);
    go_stop();
    nack = n0 | n1;
  endtask : write_reg

  task automatic read_reg(input logic [7:0] ofs, output logic [7:0] d);
    logic n0;
    begin_write(ofs, n0);
    go_start();
    put_byte({DEV_ADDR, 1'b1}, n0);
    get_byte(1'b1, d);
    go_stop();
  endtask : read_reg
endmodule : hsf_host_model

// *** test/testbench.sv ***
// Self-checking bench for the sequence, stream and page register block
`timescale 1ns/10ps
module testbench;
  import hsf_pkg::*;
  logic clk, reset, sda_out, sda_oe_n, wave_done, seq_busy, stream_valid, stream_ready;
  logic scl, host_pull, sda_line, nack;
  logic [7:0] stream_data, mem_rdata, rd;
  hsf_play_type play;
  hsf_mem_req_type mem_req;
  int fail_count, num_checks, gap, pend;
  logic [7:0] played[$];
  hsf_mem_req_type mem_log[$];

  // Open drain line with pull-up
  assign sda_line = !(host_pull || (sda_oe_n === 1'b0 && sda_out === 1'b0));

  hsf_regs DUT (.clk(clk), .reset(reset), .scl(scl), .sda_in(sda_line), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .wave_done(wave_done), .play(play), .seq_busy(seq_busy),
    .stream_data(stream_data), .stream_valid(stream_valid), .stream_ready(stream_ready),
    .mem_req(mem_req), .mem_rdata(mem_rdata));
  hsf_host_model host (.clk(clk), .sda(sda_line), .scl(scl), .sda_pull(host_pull));

  initial clk = 1'b0;
  always #20 clk = ~clk;

  // ----------------------------------------------------------------
  // Playback engine stand-in and memory traffic log
  // ----------------------------------------------------------------
  always @(negedge clk) begin
    wave_done = (pend == 1);
    if (play.start === 1'b1) begin
      played.push_back(play.id);
      pend = gap;
    end else if (pend > 0) begin
      pend--;
    end
    if (mem_req.wr === 1'b1) begin
      mem_log.push_back(mem_req);
    end
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : test_done

  task automatic test_reset();
    host.read_reg(OFS_PAGE, rd);
    check(rd, RST_BYTE);
    host.read_reg(OFS_SLOT_LAST, rd);
    check(rd, RST_BYTE);
    check({6'h00, stream_valid, seq_busy}, 8'h00);
    $display("test reset done");
  endtask : test_reset

  task automatic run_seq(input logic [7:0] ids[8], input int n, input int g);
    gap = g;
    played.delete();
    for (int k = 0; k < SLOT_COUNT; k++) begin
      host.write_reg(OFS_SLOT_FIRST + 8'(k), ids[k], nack);
    end
    host.write_reg(OFS_CTRL, 8'h01, nack);
    for (int i = 0; i < 3000 && seq_busy !== 1'b0; i++) begin
      @(negedge clk);
    end
    check({7'h00, seq_busy}, 8'h00);
    check(8'(played.size()), 8'(n));
    for (int k = 0; k < n && k < played.size(); k++) begin
      check(played[k], ids[k]);
    end
    host.read_reg(OFS_CTRL, rd);
    check(rd, 8'h00);
    $display("test sequence of %0d done", n);
  endtask : run_seq

  task automatic test_stream();
    int n;
    n = 0;
    stream_ready = 1'b0;
    host.begin_write(OFS_STREAM, nack);
    check({7'h00, nack}, 8'h00);
    for (int i = 0; i < STREAM_DEPTH; i++) begin
      host.put_byte(8'hC0 + 8'(i), nack);
      check({7'h00, nack}, 8'h00);
    end
    host.put_byte(8'hEE, nack);
    check({7'h00, nack}, 8'h01);
    host.go_stop();
    for (int i = 0; i < 200 && n < STREAM_DEPTH; i++) begin
      @(negedge clk);
      stream_ready = ~stream_ready;
      if (stream_valid === 1'b1 && stream_ready === 1'b1) begin
        check(stream_data, 8'hC0 + 8'(n));
        n++;
      end
    end
    @(negedge clk);
    stream_ready = 1'b0;
    check(8'(n), 8'h10);
    repeat (3) @(negedge clk);
    check({7'h00, stream_valid}, 8'h00);
    host.read_reg(OFS_STREAM, rd);
    check(rd, 8'h00);
    $display("test stream done");
  endtask : test_stream

  task automatic test_page();
    mem_log.delete();
    mem_rdata = 8'h5C;
    host.write_reg(OFS_SLOT_LAST, 8'h77, nack);
    host.write_reg(OFS_PAGE, 8'h03, nack);
    host.read_reg(OFS_PAGE, rd);
    check(rd, 8'h03);
    host.write_reg(OFS_SLOT_LAST, 8'h99, nack);
    host.read_reg(8'h10, rd);
    check(rd, 8'h5C);
    check(8'(mem_log.size()), 8'h01);
    if (mem_log.size() > 0) begin
      check(mem_log[0].page, 8'h03);
      check(mem_log[0].addr, OFS_SLOT_LAST);
      check(mem_log[0].wdata, 8'h99);
    end
    host.write_reg(OFS_PAGE, PAGE_CONTROL, nack);
    host.read_reg(OFS_SLOT_LAST, rd);
    check(rd, 8'h77);
    host.write_reg(8'h40, 8'h55, nack);
    host.read_reg(8'h40, rd);
    check(rd, 8'h00);
    check(8'(mem_log.size()), 8'h01);
    $display("test page done");
  endtask : test_page

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    reset = 1'b1;
    stream_ready = 1'b0;
    mem_rdata = 8'h00;
    wave_done = 1'b0;
    gap = 2;
    pend = 0;
    fail_count = 0;
    num_checks = 0;
    repeat (16) @(negedge clk);
    reset = 1'b0;
    @(negedge clk);
    test_reset();
    run_seq('{8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17, 8'h18}, 8, 2);
    run_seq('{8'h21, 8'h22, 8'h00, 8'h24, 8'h25, 8'h26, 8'h27, 8'h28}, 2, 25);
    run_seq('{8'h00, 8'h31, 8'h32, 8'h33, 8'h34, 8'h35, 8'h36, 8'h37}, 0, 3);
    test_stream();
    test_page();
    test_done();
  end

  initial begin
    #2400000;
    fail_count++;
    $display("watchdog expired at %0t", $time);
    test_done();
  end
endmodule : testbench
